// ==== hdl/rtcee_top.sv ====
// Serial-bus slave for user EEPROM reads/writes and the protected block with
// its two-key unlock. Assumes pins are open-drain, resolved by the bench.
`timescale 1ns/1ps
`include "rtcee_map.svh"

module rtcee_top #(
  parameter logic [7:0]  KEY_ADDR    = `RTCEE_KEY_ADDR_DEF,
  parameter int          WRITE_CYCLES = `RTCEE_TWC_NS / `RTCEE_CLK_NS,
  // factory content of the protected block, first byte in the top bits;
  // the value is arbitrary
  parameter logic [63:0] PROT_INIT   = 64'hFFFF_0200_0000_0001
) (
  input  wire logic core_clk,       // core clock, 250 MHz
  input  wire logic rst_n,          // synchronous reset, active low
  input  wire logic scl_i,          // serial clock pin
  input  wire logic sda_i,          // serial data pin level
  output logic      sda_o,          // data drive value, always low
  output logic      sda_oe,         // data drive enable, high pulls low
  output logic      wr_busy,        // internal write cycle running
  output logic      prot_unlocked   // protected block open for writes
);

  // ----------------------------------------------------------------
  // elaboration checks
  // ----------------------------------------------------------------
  if (WRITE_CYCLES < 1) begin : g_chk_wc
    $error("WRITE_CYCLES must be at least one");
  end
  if (KEY_ADDR > `RTCEE_RTC_TOP1) begin : g_chk_key
    $error("KEY_ADDR must lie in the clock/SRAM space");
  end

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  logic                 sda_s;
  logic                 scl_rise;
  logic                 scl_fall;
  logic                 start_det;
  logic                 stop_det;
  rtcee_pkg::rtcee_bus_e  state_q;
  rtcee_pkg::rtcee_rx_e   phase_q;
  rtcee_pkg::rtcee_lock_e lock_q;
  logic [2:0]           bit_q;
  logic [7:0]           shf_q;
  logic                 rd_q;
  logic                 ee_q;
  logic                 ack_q;
  logic                 ack_due_q;
  logic [7:0]           ptr_q;
  logic [7:0]           mem_q [0:127];
  logic [7:0]           prot_q [0:7];
  logic [7:0]           pbuf_q [0:7];
  logic [7:0]           pmask_q;
  logic [4:0]           pbase_q;
  logic                 pprot_q;
  logic                 prot_wr_q;
  logic                 busy_q;
  logic [31:0]          busy_cnt_q;
  logic                 sda_oe_q;
  logic                 sda_o_q;
  logic                 prot_open_q;
  logic                 byte_done;
  logic [7:0]           rx_byte;
  logic                 ctrl_ok;
  logic                 addr_ok;
  logic                 in_array;
  logic                 in_prot;
  logic [7:0]           rd_byte;
  logic [7:0]           ptr_rd_nxt;
  logic [7:0]           ptr_wr_nxt;
  logic                 commit;

  rtcee_line_sync u_sync (
    .core_clk  (core_clk),
    .rst_n     (rst_n),
    .scl_i     (scl_i),
    .sda_i     (sda_i),
    .sda_s     (sda_s),
    .scl_rise  (scl_rise),
    .scl_fall  (scl_fall),
    .start_det (start_det),
    .stop_det  (stop_det)
  );

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  assign byte_done = (state_q == rtcee_pkg::BUS_RX) && scl_rise && (bit_q == 3'h7);
  assign rx_byte   = {shf_q[6:0], sda_s};
  assign in_array  = (ptr_q <= `RTCEE_EE_TOP);
  assign in_prot   = (ptr_q >= `RTCEE_PROT_LO) && (ptr_q <= `RTCEE_PROT_HI);
  assign commit    = stop_det && (pmask_q != 8'h00);

  // EEPROM control bytes refused while a write cycle runs
  always_comb begin
    ctrl_ok = 1'b0;
    if (rx_byte[7:1] == `RTCEE_CTRL_RTC) begin
      ctrl_ok = 1'b1;
    end else if (rx_byte[7:1] == `RTCEE_CTRL_EE) begin
      ctrl_ok = !busy_q;
    end
  end

  // undefined locations are not acknowledged
  always_comb begin
    if (ee_q) begin
      addr_ok = (rx_byte <= `RTCEE_EE_TOP) || (rx_byte == `RTCEE_STATUS_ADDR) ||
                ((rx_byte >= `RTCEE_PROT_LO) && (rx_byte <= `RTCEE_PROT_HI));
    end else begin
      addr_ok = (rx_byte <= `RTCEE_RTC_TOP1);
    end
  end

  // read data; key location and unmodelled clock/SRAM space read as zero
  always_comb begin
    rd_byte = `RTCEE_ZERO_BYTE;
    if (ee_q && in_array) begin
      rd_byte = mem_q[ptr_q[6:0]];
    end else if (ee_q && in_prot) begin
      rd_byte = prot_q[ptr_q[2:0]];
    end
  end

  // pointer after a read byte, with block rollover
  always_comb begin
    ptr_rd_nxt = ptr_q + 8'h01;
    if (ee_q && (ptr_q == `RTCEE_EE_TOP)) begin
      ptr_rd_nxt = `RTCEE_EE_BOT;
    end else if (ee_q && (ptr_q == `RTCEE_PROT_HI)) begin
      ptr_rd_nxt = `RTCEE_PROT_LO;
    end else if (!ee_q && (ptr_q == `RTCEE_RTC_TOP0)) begin
      ptr_rd_nxt = `RTCEE_RTC_BOT0;
    end else if (!ee_q && (ptr_q == `RTCEE_RTC_TOP1)) begin
      ptr_rd_nxt = `RTCEE_RTC_BOT1;
    end
  end

  // pointer after a written byte
  always_comb begin
    ptr_wr_nxt = ptr_rd_nxt;
    if (ee_q) begin
      ptr_wr_nxt = {ptr_q[7:3], ptr_q[2:0] + 3'h1};
    end
  end

  // ----------------------------------------------------------------
  // bus state machine
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      state_q <= rtcee_pkg::BUS_IDLE;
      phase_q <= rtcee_pkg::RX_CTRL;
      bit_q   <= 3'h0;
      shf_q   <= 8'h00;
      rd_q    <= 1'b0;
      ee_q    <= 1'b0;
      ack_q   <= 1'b0;
      ack_due_q <= 1'b0;
      sda_oe_q <= 1'b0;
    end else if (start_det) begin
      state_q  <= rtcee_pkg::BUS_RX;
      phase_q  <= rtcee_pkg::RX_CTRL;
      bit_q    <= 3'h0;
      ack_due_q <= 1'b0;
      sda_oe_q <= 1'b0;
    end else if (stop_det) begin
      state_q  <= rtcee_pkg::BUS_IDLE;
      ack_due_q <= 1'b0;
      sda_oe_q <= 1'b0;
    end else begin
      case (state_q)
        rtcee_pkg::BUS_RX: begin
          if (scl_rise) begin
            shf_q <= rx_byte;
            bit_q <= bit_q + 3'h1;
          end
          // the clock fall after a start must not pass for the ninth clock
          if (byte_done) begin
            ack_due_q <= 1'b1;
            case (phase_q)
              rtcee_pkg::RX_CTRL: begin
                ack_q <= ctrl_ok;
                rd_q  <= rx_byte[0];
                ee_q  <= (rx_byte[7:1] == `RTCEE_CTRL_EE);
              end
              rtcee_pkg::RX_ADDR: ack_q <= addr_ok;
              default:            ack_q <= 1'b1;
            endcase
          end else if (scl_fall && ack_due_q) begin
            state_q   <= rtcee_pkg::BUS_ACK;
            sda_oe_q  <= ack_q;
            ack_due_q <= 1'b0;
          end
        end
        rtcee_pkg::BUS_ACK: begin
          if (scl_fall) begin
            bit_q <= 3'h0;
            if (!ack_q) begin
              state_q  <= rtcee_pkg::BUS_IDLE;
              sda_oe_q <= 1'b0;
            end else if ((phase_q == rtcee_pkg::RX_CTRL) && rd_q) begin
              state_q  <= rtcee_pkg::BUS_TX;
              shf_q    <= rd_byte;
              sda_oe_q <= ~rd_byte[7];
            end else begin
              state_q  <= rtcee_pkg::BUS_RX;
              phase_q  <= (phase_q == rtcee_pkg::RX_CTRL) ? rtcee_pkg::RX_ADDR
                                                          : rtcee_pkg::RX_DATA;
              sda_oe_q <= 1'b0;
            end
          end
        end
        rtcee_pkg::BUS_TX: begin
          if (scl_fall) begin
            if (bit_q == 3'h7) begin
              state_q  <= rtcee_pkg::BUS_MACK;
              sda_oe_q <= 1'b0;
            end else begin
              bit_q    <= bit_q + 3'h1;
              shf_q    <= {shf_q[6:0], 1'b0};
              sda_oe_q <= ~shf_q[6];
            end
          end
        end
        rtcee_pkg::BUS_MACK: begin
          if (scl_rise) begin
            ack_q <= ~sda_s;
          end else if (scl_fall) begin
            bit_q <= 3'h0;
            if (ack_q) begin
              state_q  <= rtcee_pkg::BUS_TX;
              shf_q    <= rd_byte;
              sda_oe_q <= ~rd_byte[7];
            end else begin
              state_q <= rtcee_pkg::BUS_IDLE;
            end
          end
        end
        default: begin
          state_q  <= rtcee_pkg::BUS_IDLE;
          sda_oe_q <= 1'b0;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // shared address pointer
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      ptr_q <= 8'h00;
    end else if (byte_done && (phase_q == rtcee_pkg::RX_ADDR) && addr_ok) begin
      ptr_q <= rx_byte;
    end else if (byte_done && (phase_q == rtcee_pkg::RX_DATA)) begin
      ptr_q <= ptr_wr_nxt;
    end else if ((state_q == rtcee_pkg::BUS_MACK) && scl_rise && !start_det && !stop_det) begin
      ptr_q <= ptr_rd_nxt;
    end
  end

  // ----------------------------------------------------------------
  // unlock tracker
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      lock_q <= rtcee_pkg::LK_LOCKED;
    end else if (stop_det && prot_wr_q) begin
      lock_q <= rtcee_pkg::LK_LOCKED;
    end else if (byte_done && (phase_q == rtcee_pkg::RX_DATA)) begin
      if (!ee_q && (ptr_q == KEY_ADDR) && (rx_byte == `RTCEE_KEY_FIRST) &&
          (lock_q == rtcee_pkg::LK_LOCKED)) begin
        lock_q <= rtcee_pkg::LK_KEY1;
      end else if (!ee_q && (ptr_q == KEY_ADDR) && (rx_byte == `RTCEE_KEY_SECOND) &&
                   (lock_q == rtcee_pkg::LK_KEY1)) begin
        lock_q <= rtcee_pkg::LK_OPEN;
      end else if (!(ee_q && in_prot && (lock_q == rtcee_pkg::LK_OPEN))) begin
        lock_q <= rtcee_pkg::LK_LOCKED;
      end
    end
  end

  // protected data seen in this write operation
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      prot_wr_q <= 1'b0;
    end else if (stop_det) begin
      prot_wr_q <= 1'b0;
    end else if (byte_done && (phase_q == rtcee_pkg::RX_DATA) && ee_q && in_prot) begin
      prot_wr_q <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // page buffer, filled by data bytes, drained on Stop
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      pmask_q <= 8'h00;
      pbase_q <= 5'h00;
      pprot_q <= 1'b0;
    end else if (stop_det) begin
      pmask_q <= 8'h00;
    end else if (byte_done && (phase_q == rtcee_pkg::RX_DATA) && ee_q &&
                 (in_array || (in_prot && (lock_q == rtcee_pkg::LK_OPEN)))) begin
      pmask_q[ptr_q[2:0]] <= 1'b1;
      pbase_q             <= ptr_q[7:3];
      pprot_q             <= in_prot;
      pbuf_q[ptr_q[2:0]]  <= rx_byte;
    end
  end

  // ----------------------------------------------------------------
  // nonvolatile arrays; reset models the factory state
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      for (int i = 0; i < 128; i++) begin
        mem_q[i] <= `RTCEE_ERASED;
      end
      for (int j = 0; j < 8; j++) begin
        prot_q[j] <= PROT_INIT[63 - 8 * j -: 8];
      end
    end else if (commit) begin
      for (int k = 0; k < 8; k++) begin
        if (pmask_q[k] && pprot_q) begin
          prot_q[k] <= pbuf_q[k];
        end else if (pmask_q[k]) begin
          mem_q[{pbase_q[3:0], k[2:0]}] <= pbuf_q[k];
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // internal write cycle timer
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      busy_q     <= 1'b0;
      busy_cnt_q <= 32'h0000_0000;
    end else if (commit) begin
      busy_q     <= 1'b1;
      busy_cnt_q <= 32'(WRITE_CYCLES - 1);
    end else if (busy_q && (busy_cnt_q == 32'h0000_0000)) begin
      busy_q <= 1'b0;
    end else if (busy_q) begin
      busy_cnt_q <= busy_cnt_q - 32'h0000_0001;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      sda_o_q     <= 1'b0;
      prot_open_q <= 1'b0;
    end else begin
      sda_o_q     <= 1'b0;
      prot_open_q <= (lock_q == rtcee_pkg::LK_OPEN);
    end
  end

  assign sda_o         = sda_o_q;
  assign sda_oe        = sda_oe_q;
  assign wr_busy       = busy_q;
  assign prot_unlocked = prot_open_q;

endmodule

// ==== include/rtcee_map.svh ====
// Register map, field values and timing counts of the serial EEPROM read and
// protected-block unlock logic. Assumes a 250 MHz core clock.
//
// Functional notes
// - pointer holds last accessed byte plus one for current-address reads.
// - on read control byte, acknowledge then shift out one byte at pointer.
// - master ends read with no-ack and Stop; device then releases data line.
// - one pointer serves clock/SRAM space and EEPROM space alike.
// - random read: pointer is loaded from the address byte before restart.
// - after a random read the pointer sits just past the byte delivered.
// - each master ack during a burst read sends the next sequential byte.
// - pointer advances at the end of every byte operation, wrapping at block tops and write-page ends.
// - acknowledged read of the top array byte wraps pointer to the bottom.
// - protected block is eight bytes in EEPROM space, first to last location.
// - address byte naming an undefined location is not acknowledged.
// - protected block reads need no unlock; only writes are gated.
// - unlock key location has no storage and always reads as zero.
// - protected write accepted only after first key then second key.
// - any departure from the unlock order keeps block locked, write dropped.
// - block relocks after each write operation; new write needs new keys.
// - a protected write may cover only part of the eight bytes.
// - node-address variant holds six address bytes in upper six locations.
// - EEPROM control bytes are not acknowledged during an internal write.
// - internal write cycle starts only on the Stop after data bytes.
// - during EEPROM write only low three pointer bits advance per byte.
`ifndef RTCEE_MAP_SVH
`define RTCEE_MAP_SVH

`define RTCEE_CTRL_EE      7'h57
`define RTCEE_CTRL_RTC     7'h6F
`define RTCEE_EE_TOP       8'h7F
`define RTCEE_EE_BOT       8'h00
`define RTCEE_PROT_LO      8'hF0
`define RTCEE_PROT_HI      8'hF7
`define RTCEE_STATUS_ADDR  8'hFF
`define RTCEE_RTC_TOP0     8'h1F
`define RTCEE_RTC_BOT0     8'h00
`define RTCEE_RTC_BOT1     8'h20
`define RTCEE_RTC_TOP1     8'h5F
`define RTCEE_KEY_ADDR_DEF 8'h1E
`define RTCEE_KEY_FIRST    8'h55
`define RTCEE_KEY_SECOND   8'hAA
`define RTCEE_ERASED       8'hFF
`define RTCEE_ZERO_BYTE    8'h00
`define RTCEE_CLK_NS       4
`define RTCEE_TWC_NS       5000000

`endif

// ==== include/rtcee_pkg.sv ====
// Types shared by the EEPROM read and protected unlock logic.
// Assumes rtcee_map.svh supplies all numeric values.
package rtcee_pkg;

  typedef enum logic [2:0] {
    BUS_IDLE,
    BUS_RX,
    BUS_ACK,
    BUS_TX,
    BUS_MACK
  } rtcee_bus_e;

  typedef enum logic [1:0] {
    RX_CTRL,
    RX_ADDR,
    RX_DATA
  } rtcee_rx_e;

  typedef enum logic [1:0] {
    LK_LOCKED,
    LK_KEY1,
    LK_OPEN
  } rtcee_lock_e;

endpackage

// ==== hdl/rtcee_line_sync.sv ====
// Two-stage synchroniser for the serial clock and data pins, with edge,
// Start and Stop detection. Assumes pins are asynchronous to core_clk.
`timescale 1ns/1ps

module rtcee_line_sync (
  input  wire logic core_clk,   // core clock
  input  wire logic rst_n,      // synchronous reset, active low
  input  wire logic scl_i,      // serial clock pin
  input  wire logic sda_i,      // serial data pin level
  output logic      sda_s,      // synchronised data level
  output logic      scl_rise,   // serial clock rising edge pulse
  output logic      scl_fall,   // serial clock falling edge pulse
  output logic      start_det,  // start or repeated start pulse
  output logic      stop_det    // stop pulse
);

  logic [1:0] scl_m_q;
  logic [1:0] sda_m_q;
  logic [2:0] scl_q;
  logic [2:0] sda_q;

  // --------------------------------------------------------------
  // synchroniser stages
  // --------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      scl_m_q <= 2'h3;
      sda_m_q <= 2'h3;
    end else begin
      scl_m_q <= {scl_m_q[0], scl_i};
      sda_m_q <= {sda_m_q[0], sda_i};
    end
  end

  // history beyond the second stage for edge detection
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      scl_q <= 3'h7;
      sda_q <= 3'h7;
    end else begin
      scl_q <= {scl_q[1:0], scl_m_q[1]};
      sda_q <= {sda_q[1:0], sda_m_q[1]};
    end
  end

  assign sda_s     = sda_q[0];
  assign scl_rise  = scl_q[0] & ~scl_q[1];
  assign scl_fall  = ~scl_q[0] & scl_q[1];
  assign start_det = scl_q[0] & scl_q[1] & ~sda_q[0] & sda_q[1];
  assign stop_det  = scl_q[0] & scl_q[1] & sda_q[0] & ~sda_q[1];

endmodule

// ==== verif/rtcee_top_assertions.sv ====
// Port-level checker for the serial EEPROM slave and its protected unlock.
// Assumes one core clock domain and a data wire resolved outside the block.
`timescale 1ns/1ps

module rtcee_top_assertions #(
  parameter int WRITE_CYCLES = 50
) (
  input wire logic core_clk,      // core clock
  input wire logic rst_n,         // synchronous reset, active low
  input wire logic scl_i,         // serial clock pin
  input wire logic sda_i,         // resolved data wire
  input wire logic sda_o,         // data drive value
  input wire logic sda_oe,        // data drive enable
  input wire logic wr_busy,       // write cycle running
  input wire logic prot_unlocked  // block open for writes
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  int busy_cnt_q;

  // ---------------------------------------------------------------
  // length of the running write cycle
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (!rst_n || !wr_busy) busy_cnt_q <= 0;
    else busy_cnt_q <= busy_cnt_q + 1;
  end

  sequence stop_s;
    scl_i && $rose(sda_i);
  endsequence

  sequence busy_on_s;
    $rose(wr_busy);
  endsequence

  // ---------------------------------------------------------------
  // properties
  // ---------------------------------------------------------------
  sda_low_a: assert property (sda_o == 1'b0)
    else $error("data drive value is not low");
  reset_quiet_a: assert property (disable iff (1'b0)
    !rst_n |=> !sda_oe && !wr_busy && !prot_unlocked)
    else $error("outputs active after reset");
  oe_edge_a: assert property ($changed(sda_oe) |-> !scl_i)
    else $error("data drive changed while clock high");
  stop_release_a: assert property (stop_s |=> !sda_oe [*4])
    else $error("data driven after stop");
  busy_on_stop_a: assert property (busy_on_s |-> scl_i && sda_i)
    else $error("write cycle began outside a stop");
  busy_hold_a: assert property (busy_on_s |-> wr_busy [*8])
    else $error("write cycle ended too soon");
  busy_len_a: assert property ($fell(wr_busy) |->
    busy_cnt_q >= WRITE_CYCLES - 1 && busy_cnt_q <= WRITE_CYCLES + 1)
    else $error("write cycle length wrong");
  relock_busy_a: assert property (busy_on_s |-> ##[0:2] !prot_unlocked)
    else $error("block still open after write");
endmodule

bind rtcee_top rtcee_top_assertions #(.WRITE_CYCLES(WRITE_CYCLES)) chk_u (
  .core_clk(core_clk), .rst_n(rst_n), .scl_i(scl_i), .sda_i(sda_i), .sda_o(sda_o),
  .sda_oe(sda_oe), .wr_busy(wr_busy), .prot_unlocked(prot_unlocked));

// ==== verif/rtcee_master.sv ====
// Serial bus master model: drives the clock, pulls the data wire low.
// Assumes a pull-up on the data wire and the core clock for pacing.
`timescale 1ns/1ps

module rtcee_master (
  input  wire logic core_clk,  // core clock, paces the bus
  output logic      scl_o,     // serial clock, high when idle
  output logic      pull_o,    // high pulls the data wire low
  input  wire logic sda_w      // resolved data wire
);
  int stretch = 0;

  initial begin
    scl_o = 1'b1;
    pull_o = 1'b0;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask

  // ---------------------------------------------------------------
  // bit, framing and byte steps
  // ---------------------------------------------------------------
  task automatic bit_io(input logic b, output logic r);
    tick(4 + stretch);
    pull_o = !b;
    tick(4);
    scl_o = 1'b1;
    tick(4);
    r = sda_w;
    tick(4);
    scl_o = 1'b0;
  endtask

  task automatic start();
    tick(4);
    pull_o = 1'b0;
    tick(4);
    scl_o = 1'b1;
    tick(4);
    pull_o = 1'b1;
    tick(4);
    scl_o = 1'b0;
  endtask

  task automatic stop();
    tick(4);
    pull_o = 1'b1;
    tick(4);
    scl_o = 1'b1;
    tick(4);
    pull_o = 1'b0;
    tick(4);
  endtask

  task automatic wbyte(input logic [7:0] v, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(v[i], r);
    bit_io(1'b1, r);
    ack = !r;
  endtask

  task automatic rbyte(input logic mack, output logic [7:0] v);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(1'b1, v[i]);
    bit_io(!mack, r);
  endtask
endmodule

// ==== verif/rtcee_top_tb.sv ====
// Self-checking bench for the serial EEPROM slave against a byte model.
// Assumes rtcee_master as bus master and a pulled-up data wire.
`timescale 1ns/1ps
`define CHK(nm, e, s) begin tests_run++; if ((s) !== (e)) begin n_mismatch++; \
  $display("CHECK FAILED %s exp %h got %h", nm, e, s); end end

module rtcee_top_tb;
  typedef logic [7:0] rtcee_q_t[$];
  localparam logic [7:0]  KEY   = 8'h1E;
  localparam int          WCYC  = 400;
  localparam logic [63:0] PINIT = 64'h3C5A_0011_2233_4455; // arbitrary
  logic        core_clk = 1'b0;
  logic        rst_n    = 1'b0;
  logic        scl, pull, sda_o, sda_oe, wr_busy, prot_unlocked, ack;
  wire         sda = !(sda_oe || pull);
  int          n_mismatch = 0;
  int          tests_run  = 0;
  int          seed       = 32'hf226;
  int          ptr        = 0;
  int          lk         = 0;
  logic [7:0]  ee [0:255];
  logic [7:0]  d;
  logic [63:0] ident;
  logic [7:0]  bad [4] = '{8'h80, 8'hEF, 8'hF8, 8'hFE};

  always #2 core_clk = ~core_clk;

  rtcee_top #(.KEY_ADDR(KEY), .WRITE_CYCLES(WCYC), .PROT_INIT(PINIT)) dut_u (
    .core_clk(core_clk), .rst_n(rst_n), .scl_i(scl), .sda_i(sda), .sda_o(sda_o),
    .sda_oe(sda_oe), .wr_busy(wr_busy), .prot_unlocked(prot_unlocked));
  rtcee_master m_u (.core_clk(core_clk), .scl_o(scl), .pull_o(pull), .sda_w(sda));

  // ---------------------------------------------------------------
  // bus operations with model bookkeeping
  // ---------------------------------------------------------------
  task automatic conclude();
    $display("checks %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  function automatic rtcee_q_t rq(input int n);
    for (int i = 0; i < n; i++) rq.push_back(8'($random(seed)));
  endfunction

  task automatic setp(input logic [7:0] c, input logic [7:0] a, input logic ea);
    m_u.stretch = $random(seed) & 3;
    m_u.start();
    m_u.wbyte(c, ack);
    `CHK("ctrl ack", 1'b1, ack)
    m_u.wbyte(a, ack);
    `CHK("addr ack", ea, ack)
    if (!ea) m_u.stop();
    else ptr = a;
  endtask

  task automatic rd(input logic [7:0] c, input int n);
    m_u.start();
    m_u.wbyte(c, ack);
    `CHK("read ack", 1'b1, ack)
    for (int i = 0; i < n; i++) begin
      m_u.rbyte(i < n - 1, d);
      `CHK("read byte", c[6] ? 8'h00 : ee[ptr], d)
      if (!c[6] && ptr[7:3] == 5'h1E) ident[8 * (7 - ptr[2:0]) +: 8] = d;
      if (c[6]) ptr = (ptr == 8'h1F) ? 0 : (ptr == 8'h5F) ? 8'h20 : ptr + 1;
      else ptr = (ptr == 8'h7F) ? 0 : (ptr == 8'hF7) ? 8'hF0 : ptr + 1;
    end
    m_u.stop();
  endtask

  task automatic wr(input logic [7:0] c, input logic [7:0] a, input rtcee_q_t q);
    int p;
    p = a;
    setp(c, a, 1'b1);
    foreach (q[i]) begin
      m_u.wbyte(q[i], ack);
      `CHK("data ack", 1'b1, ack)
      if (c[6]) lk = (a != KEY) ? 0 : (q[i] == 8'h55 && lk == 0) ? 1 :
                     (q[i] == 8'hAA && lk == 1) ? 2 : 0;
      else if (a < 8'h80) begin
        ee[p] = q[i];
        lk = 0;
      end
      else if (lk == 2) ee[p] = q[i];
      p = {p[7:3], p[2:0] + 3'h1};
    end
    ptr = p;
    `CHK("busy early", 1'b0, wr_busy)
    m_u.stop();
    m_u.tick(4);
    if (!c[6] && (a < 8'h80 || lk == 2)) begin
      `CHK("busy", 1'b1, wr_busy)
      m_u.start();
      m_u.wbyte(8'hAE, ack);
      `CHK("poll nack", 1'b0, ack)
      m_u.stop();
    end
    if (!c[6] && a > 8'h7F) lk = 0;
    `CHK("lock", lk == 2, prot_unlocked)
    for (int k = 0; k < 2000 && wr_busy !== 1'b0; k++) @(posedge core_clk);
    `CHK("busy end", 1'b0, wr_busy)
  endtask

  // ---------------------------------------------------------------
  // main sequence and watchdog
  // ---------------------------------------------------------------
  initial begin
    for (int i = 0; i < 256; i++) ee[i] = (i < 128) ? 8'hFF : 8'h00;
    for (int i = 0; i < 8; i++) ee[8'hF0 + i] = PINIT[63 - 8 * i -: 8];
    repeat (6) @(posedge core_clk);
    #1 rst_n = 1'b1;
    m_u.tick(6);
    `CHK("oe rst", 1'b0, sda_oe)
    `CHK("lock rst", 1'b0, prot_unlocked)
    wr(8'hAE, 8'h7A, rq(10));
    wr(8'hAE, 8'h10, rq(8));
    rd(8'hAF, 1);
    setp(8'hAE, 8'h7E, 1'b1);
    rd(8'hAF, 4);
    rd(8'hAF, 1);
    setp(8'hDE, 8'h10, 1'b1);
    m_u.stop();
    rd(8'hAF, 2);
    rd(8'hDF, 1);
    foreach (bad[i]) setp(8'hAE, bad[i], 1'b0);
    setp(8'hDE, 8'h60, 1'b0);
    setp(8'hAE, 8'hF0, 1'b1);
    rd(8'hAF, 9);
    `CHK("node id", {PINIT[47:24], 16'hFFFE, PINIT[23:0]}, {ident[47:24], 16'hFFFE, ident[23:0]})
    setp(8'hDE, KEY, 1'b1);
    rd(8'hDF, 1);
    wr(8'hAE, 8'hF0, rq(1));
    wr(8'hDE, KEY, '{8'hAA});
    wr(8'hDE, KEY, '{8'h55});
    wr(8'hDE, KEY, '{8'h12});
    wr(8'hAE, 8'hF1, rq(1));
    wr(8'hDE, KEY, '{8'h55});
    wr(8'hDE, KEY, '{8'hAA});
    wr(8'hAE, 8'hF3, rq(2));
    wr(8'hAE, 8'hF5, rq(1));
    setp(8'hAE, 8'hF0, 1'b1);
    rd(8'hAF, 8);
    conclude();
  end

  initial begin
    repeat (80000) @(posedge core_clk);
    n_mismatch++;
    conclude();
  end
endmodule
